// *** cuio_pkg.sv ***
`default_nettype none
package cuio_pkg;
  // Data widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FUNC_W = 3;
  localparam int unsigned CNT_W = 2;

  // Sense and load function select codes
  localparam logic [2:0] FN_IRQ = 3'h0;
  localparam logic [2:0] FN_DIAG = 3'h1;
  localparam logic [2:0] FN_STATUS = 3'h3;
  localparam logic [2:0] FN_PRT_ADDR = 3'h4;
  localparam logic [2:0] FN_RD_ADDR = 3'h5;
  localparam logic [2:0] FN_PUN_ADDR = 3'h6;

  // Test code: zero tests not-ready/check, else a mask of busy conditions
  localparam logic [2:0] TST_NRDY = 3'h0;
  localparam int unsigned TST_RF = 0;
  localparam int unsigned TST_PUN = 1;
  localparam int unsigned TST_PRT = 2;

  // Status byte 1 positions (bit 0 is the most significant bit)
  localparam int unsigned S1_READ_CHK = 7;
  localparam int unsigned S1_PUN_CHK = 6;
  localparam int unsigned S1_PUN_INV = 5;
  localparam int unsigned S1_PRT_DATA = 4;
  localparam int unsigned S1_CLUTCH = 3;
  localparam int unsigned S1_HOPPER = 2;
  localparam int unsigned S1_FEED_CHK = 1;
  localparam int unsigned S1_NOOP = 0;
  // Status byte 2 positions
  localparam int unsigned S2_BUF1 = 7;
  localparam int unsigned S2_BUF2 = 6;
  localparam int unsigned S2_WAIT1 = 5;
  localparam int unsigned S2_WAIT2 = 4;
  localparam int unsigned S2_OVERRUN = 3;
  localparam int unsigned S2_HOPCYC = 2;
  localparam int unsigned S2_CNT_LSB = 0;
  localparam int unsigned S2_IRQ_PEND = 4;

  // Reset values and sense address step
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  typedef enum logic [1:0] {OP_TEST, OP_ADVANCE, OP_LOAD, OP_SENSE} cuio_op_t;

  typedef struct packed {
    logic [1:0] cnt;
  } cuio_cnt_t;

  typedef struct packed {
    logic [2:0] startSync;
    logic startLvl;
    logic rfBusy;
    logic rfFromSec;
    logic punBusy;
    logic prtBusy;
    logic [7:0] stat1;
    logic buf1Busy;
    logic buf2Busy;
    logic wait1;
    logic wait2;
    logic overrun;
    logic hopCycle;
    logic intPend;
    logic [15:0] prtAddr;
    logic [15:0] rdAddr;
    logic [15:0] punAddr;
    logic respValid;
    logic branchTaken;
    logic levelSwitch;
    logic repeatInstr;
    logic nextSeq;
    logic progCheck;
    logic procCheck;
    logic senseValid;
    logic [7:0] senseFirst;
    logic [7:0] senseSecond;
    logic [15:0] senseAddrFirst;
    logic [15:0] senseAddrSecond;
  } cuio_state_t;
endpackage : cuio_pkg
`default_nettype wire

// *** cuio_proc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cuio_proc_model
(
  input wire logic ref_clk,
  input wire logic senseValid,
  input wire logic [7:0] senseFirst,
  input wire logic [7:0] senseSecond,
  input wire logic [15:0] senseAddrFirst,
  input wire logic [15:0] senseAddrSecond,
  output logic instrValid,
  output cuio_pkg::cuio_op_t instrOp,
  output logic [2:0] instrFunc,
  output logic instrFeedSec,
  output logic [15:0] loadData,
  output logic [15:0] operandAddr
);
  logic [7:0] mem [16];

  // Store sensed bytes where the unit points them
  always @(posedge ref_clk)
    if (senseValid === 1'h1)
    begin
      mem[senseAddrFirst[3:0]] <= senseFirst;
      mem[senseAddrSecond[3:0]] <= senseSecond;
    end

  // Idle instruction lines
  initial
  begin
    instrValid = 1'h0;
    instrOp = cuio_pkg::OP_TEST;
    instrFunc = 3'h0;
    instrFeedSec = 1'h0;
    loadData = 16'h0000;
    operandAddr = 16'h0000;
  end

  // One instruction for one edge; released operand lines are scrambled
  task automatic issue(input cuio_pkg::cuio_op_t op, input logic [2:0] fn, input logic sec,
                       input logic [15:0] adr);
    @(negedge ref_clk);
    instrValid = 1'h1;
    instrOp = op;
    instrFunc = fn;
    instrFeedSec = sec;
    operandAddr = adr;
    loadData = {mem[adr[3:0] - 4'h1], mem[adr[3:0]]}; // High position addressing
    @(negedge ref_clk);
    instrValid = 1'h0;
    loadData = ~loadData;
    operandAddr = ~operandAddr;
  endtask : issue
endmodule : cuio_proc_model
`default_nettype wire

// *** cuio_status_logic.sv ***
// Functional notes
// - Test branch taken if any chosen condition
// - Read/feed busy on any accepted command
// - Punch or printer busy on matching command
// - Printer busy drops before printing completes
// - Feed check drops busy; else end-of-operation
// - Test branch never writes condition register
// - Level advance switches, repeats or proceeds
// - Load two bytes; repeat while register busy
// - Bad code: program or processor check
// - Interrupt disable discards pending, blocks later
// - Sense 000 returns pending in bit3
// - Sense codes select diag, status, addresses
// - Sense bytes go to address, address-1
// - Read/punch check cleared by three sources
// - Bits 2,3,4,7 cleared by status sense
// - Hopper check and feed check clearing
// - Print buffer busy set and cleared
// - Card waiting per hopper after read/feed
// - Overrun flags lost cycle-steal data
// - Hopper cycle bit until card leaves
// - Two-bit in-transport card counter
// - No-op on feed check or empty wait
`timescale 1ns/1ns
`default_nettype none
module cuio_status_logic
#(
  parameter bit INT_MODEL = 1'b1,
  parameter bit DUAL_LEVEL = 1'b1,
  parameter int unsigned CNT_BITS = 2
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire cuio_pkg::cuio_op_t instrOp,
  input wire logic [2:0] instrFunc,
  input wire logic instrFeedSec,
  input wire logic [15:0] loadData,
  input wire logic [15:0] operandAddr,
  input wire logic intEnable,
  input wire logic intLevel7En,
  input wire logic dualLevelEn,
  input wire logic notReady,
  input wire logic [15:0] diagWord,
  input wire logic bioIssue,
  input wire logic bioPunch,
  input wire logic bioPrint,
  input wire logic bioFeedSec,
  input wire logic bioBufSel,
  input wire logic waitCardPresent,
  input wire logic readEndEv,
  input wire logic punchEndEv,
  input wire logic printReleaseEv,
  input wire logic printDoneEv,
  input wire logic printDoneBuf2,
  input wire logic feedCheckEv,
  input wire logic readCheckEv,
  input wire logic punchCheckEv,
  input wire logic punchInvalidEv,
  input wire logic printDataChkEv,
  input wire logic clutchChkEv,
  input wire logic hopperFailEv,
  input wire logic hopperClearEv,
  input wire logic cardLeftWaitEv,
  input wire logic cardStackedEv,
  input wire logic machineCheck,
  input wire logic overrunEv,
  input wire logic runoutClear,
  input wire logic checkReset,
  input wire logic operatorStartPin,
  output logic bioAccept,
  output logic respValid,
  output logic branchTaken,
  output logic levelSwitch,
  output logic repeatInstr,
  output logic nextSeq,
  output logic progCheck,
  output logic procCheck,
  output logic condRegWrite,
  output logic senseValid,
  output logic [7:0] senseFirst,
  output logic [7:0] senseSecond,
  output logic [15:0] senseAddrFirst,
  output logic [15:0] senseAddrSecond,
  output logic [15:0] unitStatusWord,
  output logic rfBusy,
  output logic punBusy,
  output logic prtBusy,
  output logic intPending
);
  if (CNT_BITS != cuio_pkg::CNT_W)
  begin : gCntChk
    $error("transit counter must be two bits wide");
  end

  cuio_pkg::cuio_state_t state_ff;
  cuio_pkg::cuio_state_t nxt_state;
  logic [1:0] transitCnt;
  logic [7:0] stat2;
  logic startPress;
  logic needCard;
  logic noopCond;
  logic [2:0] busyVec;
  logic testCond;
  logic senseOp;
  logic loadOp;
  logic badFunc;
  logic loadBusy;
  logic opEnd;

  // Cards counted between wait station and stackers
  cuio_transit_cnt u_cnt
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(runoutClear),
    .incr(cardLeftWaitEv),
    .decr(cardStackedEv && !machineCheck),
    .count(transitCnt)
  );

  // Command acceptance and no-op detection
  assign needCard = bioPunch || bioPrint;
  assign noopCond = bioIssue && (state_ff.stat1[cuio_pkg::S1_FEED_CHK] ||
                    (needCard && !waitCardPresent));
  assign bioAccept = bioIssue && !noopCond && !state_ff.rfBusy && !notReady;

  // Operator start key, debounced once two later stages agree
  assign startPress = (state_ff.startSync[1] == state_ff.startSync[2]) &&
                      state_ff.startSync[2] && !state_ff.startLvl;

  // Status byte 2 assembly
  always_comb
  begin
    stat2 = cuio_pkg::BYTE_RST;
    stat2[cuio_pkg::S2_BUF1] = state_ff.buf1Busy;
    stat2[cuio_pkg::S2_BUF2] = state_ff.buf2Busy;
    stat2[cuio_pkg::S2_WAIT1] = state_ff.wait1;
    stat2[cuio_pkg::S2_WAIT2] = state_ff.wait2;
    stat2[cuio_pkg::S2_OVERRUN] = state_ff.overrun;
    stat2[cuio_pkg::S2_HOPCYC] = state_ff.hopCycle;
    stat2[cuio_pkg::S2_CNT_LSB +: cuio_pkg::CNT_W] = transitCnt;
  end

  // Condition selection for test and advance
  assign busyVec[cuio_pkg::TST_RF] = state_ff.rfBusy && (state_ff.rfFromSec == instrFeedSec);
  assign busyVec[cuio_pkg::TST_PUN] = state_ff.punBusy;
  assign busyVec[cuio_pkg::TST_PRT] = state_ff.prtBusy;
  assign testCond = (instrFunc == cuio_pkg::TST_NRDY) ?
                    (notReady || state_ff.stat1[cuio_pkg::S1_READ_CHK] ||
                     state_ff.stat1[cuio_pkg::S1_PUN_CHK] ||
                     state_ff.stat1[cuio_pkg::S1_FEED_CHK]) :
                    |(busyVec & instrFunc);

  // Load and sense decode
  assign senseOp = instrValid && (instrOp == cuio_pkg::OP_SENSE);
  assign loadOp = instrValid && (instrOp == cuio_pkg::OP_LOAD);
  always_comb
  begin
    badFunc = 1'b1;
    loadBusy = 1'b0;
    case (instrFunc)
      cuio_pkg::FN_IRQ,
      cuio_pkg::FN_DIAG,
      cuio_pkg::FN_STATUS: badFunc = !senseOp;
      cuio_pkg::FN_PRT_ADDR:
      begin
        badFunc = 1'b0;
        loadBusy = state_ff.buf1Busy || state_ff.buf2Busy;
      end
      cuio_pkg::FN_RD_ADDR:
      begin
        badFunc = 1'b0;
        loadBusy = state_ff.rfBusy;
      end
      cuio_pkg::FN_PUN_ADDR:
      begin
        badFunc = 1'b0;
        loadBusy = state_ff.punBusy;
      end
      default: badFunc = 1'b1;
    endcase
  end

  // Next-state logic
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.startSync = {state_ff.startSync[1:0], operatorStartPin};
    if (state_ff.startSync[1] == state_ff.startSync[2])
      nxt_state.startLvl = state_ff.startSync[2];
    // Busy conditions: set wins, feed check drops at once
    if (readEndEv || feedCheckEv)
      nxt_state.rfBusy = 1'b0;
    if (punchEndEv || feedCheckEv)
      nxt_state.punBusy = 1'b0;
    if (printReleaseEv || feedCheckEv)
      nxt_state.prtBusy = 1'b0;
    if (bioAccept)
    begin
      nxt_state.rfBusy = 1'b1;
      nxt_state.rfFromSec = bioFeedSec;
      nxt_state.punBusy = bioPunch || nxt_state.punBusy;
      nxt_state.prtBusy = bioPrint || nxt_state.prtBusy;
    end
    // Print buffers: completion clears, acceptance sets
    if (printDoneEv && !printDoneBuf2)
      nxt_state.buf1Busy = 1'b0;
    if (printDoneEv && printDoneBuf2)
      nxt_state.buf2Busy = 1'b0;
    if (bioAccept && bioPrint && !bioBufSel)
      nxt_state.buf1Busy = 1'b1;
    if (bioAccept && bioPrint && bioBufSel)
      nxt_state.buf2Busy = 1'b1;
    // Card waiting flags
    if (cardLeftWaitEv || runoutClear)
    begin
      nxt_state.wait1 = 1'b0;
      nxt_state.wait2 = 1'b0;
    end
    if (state_ff.rfBusy && !nxt_state.rfBusy && !feedCheckEv)
    begin
      if (state_ff.rfFromSec)
        nxt_state.wait2 = 1'b1;
      else
        nxt_state.wait1 = 1'b1;
    end
    // Overrun and hopper cycle
    if (bioAccept)
      nxt_state.overrun = 1'b0;
    if (overrunEv)
      nxt_state.overrun = 1'b1;
    if (hopperClearEv)
      nxt_state.hopCycle = 1'b0;
    if (bioAccept)
      nxt_state.hopCycle = 1'b1;
    // Status byte 1 clears
    if (bioAccept || runoutClear || checkReset)
    begin
      nxt_state.stat1[cuio_pkg::S1_READ_CHK] = 1'b0;
      nxt_state.stat1[cuio_pkg::S1_PUN_CHK] = 1'b0;
    end
    if ((senseOp && instrFunc == cuio_pkg::FN_STATUS) || runoutClear || checkReset)
    begin
      nxt_state.stat1[cuio_pkg::S1_PUN_INV] = 1'b0;
      nxt_state.stat1[cuio_pkg::S1_PRT_DATA] = 1'b0;
      nxt_state.stat1[cuio_pkg::S1_CLUTCH] = 1'b0;
      nxt_state.stat1[cuio_pkg::S1_NOOP] = 1'b0;
    end
    if (runoutClear || startPress)
      nxt_state.stat1[cuio_pkg::S1_HOPPER] = 1'b0;
    if (runoutClear)
      nxt_state.stat1[cuio_pkg::S1_FEED_CHK] = 1'b0;
    // Status byte 1 sets, winning over clears
    if (readCheckEv)
      nxt_state.stat1[cuio_pkg::S1_READ_CHK] = 1'b1;
    if (punchCheckEv)
      nxt_state.stat1[cuio_pkg::S1_PUN_CHK] = 1'b1;
    if (punchInvalidEv)
      nxt_state.stat1[cuio_pkg::S1_PUN_INV] = 1'b1;
    if (printDataChkEv)
      nxt_state.stat1[cuio_pkg::S1_PRT_DATA] = 1'b1;
    if (clutchChkEv)
      nxt_state.stat1[cuio_pkg::S1_CLUTCH] = 1'b1;
    if (hopperFailEv)
      nxt_state.stat1[cuio_pkg::S1_HOPPER] = 1'b1;
    if (feedCheckEv)
      nxt_state.stat1[cuio_pkg::S1_FEED_CHK] = 1'b1;
    if (noopCond)
      nxt_state.stat1[cuio_pkg::S1_NOOP] = 1'b1;
    // Busy-to-idle edges, feed check and no-op raise op-end
    opEnd = (state_ff.rfBusy && !nxt_state.rfBusy) ||
            (state_ff.punBusy && !nxt_state.punBusy) ||
            (state_ff.prtBusy && !nxt_state.prtBusy) ||
            (state_ff.buf1Busy && !nxt_state.buf1Busy) ||
            (state_ff.buf2Busy && !nxt_state.buf2Busy) ||
            feedCheckEv || noopCond;
    // Interrupt pending, discarded while disabled
    if (senseOp && instrFunc == cuio_pkg::FN_IRQ)
      nxt_state.intPend = 1'b0;
    if (opEnd)
      nxt_state.intPend = 1'b1;
    if (!intEnable || !INT_MODEL)
      nxt_state.intPend = 1'b0;
    // Instruction answer, one cycle after the request
    nxt_state.respValid = instrValid;
    nxt_state.branchTaken = 1'b0;
    nxt_state.levelSwitch = 1'b0;
    nxt_state.repeatInstr = 1'b0;
    nxt_state.nextSeq = 1'b0;
    nxt_state.progCheck = 1'b0;
    nxt_state.procCheck = 1'b0;
    nxt_state.senseValid = 1'b0;
    if (instrValid)
    begin
      case (instrOp)
        cuio_pkg::OP_TEST:
        begin
          nxt_state.branchTaken = testCond;
          nxt_state.nextSeq = !testCond;
        end
        cuio_pkg::OP_ADVANCE:
        begin
          nxt_state.levelSwitch = testCond && DUAL_LEVEL && dualLevelEn;
          nxt_state.repeatInstr = testCond && !(DUAL_LEVEL && dualLevelEn);
          nxt_state.nextSeq = !testCond;
        end
        cuio_pkg::OP_LOAD,
        cuio_pkg::OP_SENSE:
        begin
          if (badFunc)
          begin
            nxt_state.progCheck = INT_MODEL && intLevel7En;
            nxt_state.procCheck = !(INT_MODEL && intLevel7En);
          end
          else if (loadOp && loadBusy)
            nxt_state.repeatInstr = 1'b1;
          else
            nxt_state.nextSeq = 1'b1;
          if (loadOp && !badFunc && !loadBusy)
          begin
            case (instrFunc)
              cuio_pkg::FN_PRT_ADDR: nxt_state.prtAddr = loadData;
              cuio_pkg::FN_RD_ADDR: nxt_state.rdAddr = loadData;
              default: nxt_state.punAddr = loadData;
            endcase
          end
          if (senseOp && !badFunc)
          begin
            nxt_state.senseValid = 1'b1;
            nxt_state.senseAddrFirst = operandAddr;
            nxt_state.senseAddrSecond = operandAddr - cuio_pkg::ADDR_STEP;
            // First byte carries the low-order half for addresses, the high-order half for 000, diag and status
            case (instrFunc)
              cuio_pkg::FN_IRQ:
              begin
                nxt_state.senseFirst = diagWord[15:8];
                nxt_state.senseSecond = diagWord[7:0];
                nxt_state.senseSecond[cuio_pkg::S2_IRQ_PEND] = state_ff.intPend;
              end
              cuio_pkg::FN_DIAG:
              begin
                nxt_state.senseFirst = diagWord[15:8];
                nxt_state.senseSecond = diagWord[7:0];
              end
              cuio_pkg::FN_STATUS:
              begin
                nxt_state.senseFirst = state_ff.stat1;
                nxt_state.senseSecond = stat2;
              end
              cuio_pkg::FN_PRT_ADDR:
              begin
                nxt_state.senseFirst = state_ff.prtAddr[7:0];
                nxt_state.senseSecond = state_ff.prtAddr[15:8];
              end
              cuio_pkg::FN_RD_ADDR:
              begin
                nxt_state.senseFirst = state_ff.rdAddr[7:0];
                nxt_state.senseSecond = state_ff.rdAddr[15:8];
              end
              default:
              begin
                nxt_state.senseFirst = state_ff.punAddr[7:0];
                nxt_state.senseSecond = state_ff.punAddr[15:8];
              end
            endcase
          end
        end
        default: nxt_state.nextSeq = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // Outputs
  assign respValid = state_ff.respValid;
  assign branchTaken = state_ff.branchTaken;
  assign levelSwitch = state_ff.levelSwitch;
  assign repeatInstr = state_ff.repeatInstr;
  assign nextSeq = state_ff.nextSeq;
  assign progCheck = state_ff.progCheck;
  assign procCheck = state_ff.procCheck;
  assign condRegWrite = 1'b0;
  assign senseValid = state_ff.senseValid;
  assign senseFirst = state_ff.senseFirst;
  assign senseSecond = state_ff.senseSecond;
  assign senseAddrFirst = state_ff.senseAddrFirst;
  assign senseAddrSecond = state_ff.senseAddrSecond;
  assign unitStatusWord = {state_ff.stat1, stat2};
  assign rfBusy = state_ff.rfBusy;
  assign punBusy = state_ff.punBusy;
  assign prtBusy = state_ff.prtBusy;
  assign intPending = state_ff.intPend;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seqStatusSense;
    senseOp && instrFunc == cuio_pkg::FN_STATUS;
  endsequence

  accept_rf_busy_a: assert property (bioAccept |=> rfBusy)
    else $error("read/feed busy not raised");
  punch_busy_a: assert property (bioAccept && bioPunch |=> punBusy)
    else $error("punch busy not raised");
  feed_chk_drop_a: assert property (feedCheckEv && !bioIssue |=> !rfBusy && !punBusy && !prtBusy)
    else $error("busy survived feed check");
  test_no_cc_a: assert property (instrValid && instrOp == cuio_pkg::OP_TEST |=> respValid && !condRegWrite)
    else $error("test answer wrong");
  load_loop_a: assert property (loadOp && instrFunc == cuio_pkg::FN_PRT_ADDR && (stat2[cuio_pkg::S2_BUF1] || stat2[cuio_pkg::S2_BUF2]) |=> repeatInstr && $stable(state_ff.prtAddr))
    else $error("load not looped while busy");
  irq_discard_a: assert property (!intEnable |=> !intPending)
    else $error("pending survived disable");
  status_order_a: assert property (seqStatusSense |=> senseValid && senseFirst == $past(unitStatusWord[15:8]) && senseSecond == $past(unitStatusWord[7:0]))
    else $error("status bytes out of order");
  sense_addr_a: assert property (senseValid |-> senseAddrSecond == senseAddrFirst - cuio_pkg::ADDR_STEP)
    else $error("second sense address wrong");
  branch_cond_a: assert property (instrValid && instrOp == cuio_pkg::OP_TEST |=> branchTaken == $past(testCond) && nextSeq != branchTaken)
    else $error("branch decision wrong");
  noop_set_a: assert property (noopCond |=> unitStatusWord[8 + cuio_pkg::S1_NOOP] && !$rose(rfBusy))
    else $error("no-op bit not set");
endmodule : cuio_status_logic
`default_nettype wire

// *** cuio_status_logic_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module cuio_status_logic_test;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic instrValid, instrFeedSec, senseValid, bioAccept, respValid, branchTaken, levelSwitch;
  logic repeatInstr, nextSeq, progCheck, procCheck, condRegWrite, rfBusy, punBusy, prtBusy;
  logic intPending;
  cuio_pkg::cuio_op_t instrOp;
  logic [2:0] instrFunc;
  logic [7:0] senseFirst, senseSecond;
  logic [15:0] loadData, operandAddr, senseAddrFirst, senseAddrSecond, unitStatusWord;
  logic intEnable = 1'h0, intLevel7En = 1'h0, dualLevelEn = 1'h0, notReady = 1'h0;
  logic bioIssue = 1'h0, bioPunch = 1'h0, bioPrint = 1'h0, bioFeedSec = 1'h0;
  logic bioBufSel = 1'h0, waitCardPresent = 1'h0, printDoneBuf2 = 1'h0;
  logic machineCheck = 1'h0, operatorStartPin = 1'h0;
  logic [15:0] diagWord = 16'ha54a;
  logic [16:0] ev = 17'h00000;
  wire readEndEv, punchEndEv, printReleaseEv, printDoneEv, feedCheckEv, readCheckEv;
  wire punchCheckEv, punchInvalidEv, printDataChkEv, clutchChkEv, hopperFailEv;
  wire hopperClearEv, cardLeftWaitEv, cardStackedEv, overrunEv, runoutClear, checkReset;
  int n_checks = 0;
  int num_errors = 0;
  localparam int RDE = 16, PRL = 14, PDN = 13, FCK = 12, RCK = 11, HCL = 5, CLW = 4;
  localparam int CST = 3, OVR = 2, RUN = 1, HFL = 6;

  // Event pulses fan out from one vector
  assign {readEndEv, punchEndEv, printReleaseEv, printDoneEv, feedCheckEv, readCheckEv,
          punchCheckEv, punchInvalidEv, printDataChkEv, clutchChkEv, hopperFailEv,
          hopperClearEv, cardLeftWaitEv, cardStackedEv, overrunEv, runoutClear,
          checkReset} = ev;

  // Clock, device and processor model
  always #20 ref_clk = ~ref_clk;
  cuio_status_logic i_cuio_status_logic (.*);
  cuio_proc_model i_cuio_proc_model (.*);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic pulse(input int b);
    @(negedge ref_clk);
    ev = 17'h00001 << b;
    @(negedge ref_clk);
    ev = 17'h00000;
  endtask : pulse

  task automatic bio(input logic acc);
    @(negedge ref_clk);
    bioIssue = 1'h1;
    #1 chk(bioAccept, acc);
    @(negedge ref_clk);
    bioIssue = 1'h0;
  endtask : bio

  task automatic ins(input cuio_pkg::cuio_op_t op, input logic [2:0] fn, input logic [15:0] a);
    i_cuio_proc_model.issue(op, fn, 1'h0, a);
  endtask : ins

  task automatic tst(input logic [2:0] fn, input logic sec, input logic exp);
    i_cuio_proc_model.issue(cuio_pkg::OP_TEST, fn, sec, 16'h0000);
    chk({respValid, branchTaken, condRegWrite}, {1'h1, exp, 1'h0});
  endtask : tst

  // Hang guard
  initial
  begin
    #20000;
    num_errors++;
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'h0;
    chk(unitStatusWord, 16'h0000);
    {waitCardPresent, bioPunch, bioPrint, bioBufSel} = 4'hf;
    bio(1'h1);
    chk({rfBusy, punBusy, prtBusy}, 16'h0007);
    chk({unitStatusWord[cuio_pkg::S2_BUF2], unitStatusWord[cuio_pkg::S2_HOPCYC]}, 16'h3);
    tst(3'h1, 1'h0, 1'h1);
    tst(3'h1, 1'h1, 1'h0);
    tst(3'h2, 1'h0, 1'h1);
    tst(3'h4, 1'h0, 1'h1);
    tst(3'h0, 1'h0, 1'h0);
    notReady = 1'h1;
    tst(3'h0, 1'h0, 1'h1);
    notReady = 1'h0;
    dualLevelEn = 1'h1;
    ins(cuio_pkg::OP_ADVANCE, 3'h1, 16'h0000);
    chk({levelSwitch, repeatInstr, nextSeq}, 16'h4);
    dualLevelEn = 1'h0;
    ins(cuio_pkg::OP_ADVANCE, 3'h1, 16'h0000);
    chk({levelSwitch, repeatInstr, nextSeq}, 16'h2);
    ins(cuio_pkg::OP_ADVANCE, 3'h0, 16'h0000);
    chk({levelSwitch, repeatInstr, nextSeq}, 16'h1);
    ins(cuio_pkg::OP_LOAD, cuio_pkg::FN_PRT_ADDR, 16'h0005);
    chk(repeatInstr, 1'h1);
    pulse(PRL);
    chk({prtBusy, unitStatusWord[cuio_pkg::S2_BUF2]}, 16'h1);
    pulse(HCL);
    chk(unitStatusWord[cuio_pkg::S2_HOPCYC], 1'h0);
    pulse(FCK);
    chk({rfBusy, punBusy, unitStatusWord[15:8]}, 16'h02);
    bio(1'h0);
    ins(cuio_pkg::OP_SENSE, cuio_pkg::FN_STATUS, 16'h0003);
    chk({senseFirst, senseSecond}, 16'h0340);
    chk(senseAddrSecond, 16'h0002);
    chk(unitStatusWord[15:8], 8'h02);
    pulse(CLW);
    pulse(CLW);
    pulse(CST);
    chk(unitStatusWord[1:0], 2'h1);
    pulse(RUN);
    chk({unitStatusWord[15:8], unitStatusWord[1:0]}, 16'h0);
    pulse(HFL);
    chk(unitStatusWord[8 + cuio_pkg::S1_HOPPER], 1'h1);
    operatorStartPin = 1'h1;
    repeat (5) @(negedge ref_clk);
    chk(unitStatusWord[8 + cuio_pkg::S1_HOPPER], 1'h0);
    printDoneBuf2 = 1'h1;
    pulse(PDN);
    chk(unitStatusWord[7:0], 8'h00);
    i_cuio_proc_model.mem[5] = 8'h34;
    i_cuio_proc_model.mem[4] = 8'h12;
    ins(cuio_pkg::OP_LOAD, cuio_pkg::FN_PRT_ADDR, 16'h0005);
    chk(repeatInstr, 1'h0);
    ins(cuio_pkg::OP_SENSE, cuio_pkg::FN_PRT_ADDR, 16'h0009);
    @(negedge ref_clk);
    chk({i_cuio_proc_model.mem[8], i_cuio_proc_model.mem[9]}, 16'h1234);
    intLevel7En = 1'h1;
    ins(cuio_pkg::OP_SENSE, 3'h2, 16'h0003);
    chk({progCheck, procCheck}, 16'h2);
    intLevel7En = 1'h0;
    ins(cuio_pkg::OP_LOAD, 3'h7, 16'h0003);
    chk({progCheck, procCheck}, 16'h1);
    intEnable = 1'h1;
    @(negedge ref_clk);
    chk(intPending, 1'h0);
    pulse(RCK);
    pulse(OVR);
    chk({unitStatusWord[8 + cuio_pkg::S1_READ_CHK], unitStatusWord[cuio_pkg::S2_OVERRUN]}, 16'h3);
    {bioPunch, bioPrint} = 2'h0;
    bio(1'h1);
    chk({unitStatusWord[8 + cuio_pkg::S1_READ_CHK], unitStatusWord[cuio_pkg::S2_OVERRUN]}, 16'h0);
    pulse(RDE);
    chk({intPending, unitStatusWord[cuio_pkg::S2_WAIT1]}, 16'h3);
    ins(cuio_pkg::OP_SENSE, cuio_pkg::FN_DIAG, 16'h0003);
    chk({senseFirst, senseSecond}, 16'ha54a);
    ins(cuio_pkg::OP_SENSE, cuio_pkg::FN_IRQ, 16'h0003);
    chk({senseFirst, senseSecond}, 16'ha55a);
    pulse(FCK);
    chk(intPending, 1'h1);
    intEnable = 1'h0;
    @(negedge ref_clk);
    chk(intPending, 1'h0);
    summarize();
  end
endmodule : cuio_status_logic_test
`default_nettype wire

// *** cuio_transit_cnt.sv ***
`timescale 1ns/1ns
`default_nettype none
module cuio_transit_cnt
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic incr,
  input wire logic decr,
  output logic [1:0] count
);
  cuio_pkg::cuio_cnt_t cnt_ff;
  cuio_pkg::cuio_cnt_t nxt_cnt;

  // Card-in-transport count; both events at once leave it unchanged
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (clear)
    begin
      nxt_cnt.cnt = '0;
    end
    else if (incr && !decr)
    begin
      nxt_cnt.cnt = cnt_ff.cnt + 2'h1;
    end
    else if (decr && !incr)
    begin
      nxt_cnt.cnt = cnt_ff.cnt - 2'h1;
    end
  end

  // Power-up clear via system reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign count = cnt_ff.cnt;

  // Count rises by exactly one per lone increment
  cnt_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    incr && !decr && !clear |=> count == $past(count) + 2'h1)
    else $error("transit count did not advance");
endmodule : cuio_transit_cnt
`default_nettype wire
